// [hw/cbi_pkg.sv]
// Shared constants, state codes and carriers for the bus interface block.
// Assumes a single 250 MHz system clock that oversamples every pin.
package cbi_pkg;

    // ==========================================================
    // Clocking and synchroniser.
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Sampled pin vector layout.
    localparam int PIN_PHI1 = 0;
    localparam int PIN_PHI2 = 1;
    localparam int PIN_RESET_N = 2;
    localparam int PIN_HALT_N = 3;
    localparam int PIN_FLOAT = 4;
    localparam int PIN_DDE = 5;
    localparam int PIN_DATA_LSB = 6;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int PIN_W = PIN_DATA_LSB + DATA_W;

    // ==========================================================
    // Restart vectors and reset values.
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
    localparam logic [7:0] UPPER_ONES = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // ==========================================================
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_VEC_HI = 3'h1,
        ST_VEC_LO = 3'h2,
        ST_RUN = 3'h3,
        ST_HALT = 3'h4,
        ST_WAIT = 3'h5
    } cbi_state_e;

    // ==========================================================
    // One bus cycle asked for by the processor core.
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cbi_bus_req_s;

endpackage

// [hw/cbi_pin_sync.sv]
// Two-flop synchroniser for the pin vector, with edge pulses.
// Assumes pins change asynchronously to clk_in.
module cbi_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Raw pins.
    input wire logic [W-1:0] pins_in,
    // Synchronised level and one-cycle edge pulses.
    output logic [W-1:0] level_out,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);
    import cbi_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] last;
    } cbi_sync_s;

    cbi_sync_s st_reg;
    cbi_sync_s st_next;

    // ==========================================================
    // The first stage feeds only the second; edges use later stages.
    always_comb begin
        st_next = st_reg;
        st_next.meta = pins_in;
        st_next.sync = st_reg.meta;
        st_next.last = st_reg.sync;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.sync;
    assign rise_out = st_reg.sync & ~st_reg.last;
    assign fall_out = ~st_reg.sync & st_reg.last;

endmodule

// [hw/cbi_bus_ctrl.sv]
// Bus interface and processor control: restart, halt, wait and float.
// Assumes the two-phase clock, restart, halt, float and data-enable
// arrive as pins and are oversampled by clk_in; the core is on clk_in.
//
// How it works
// R1 - Phase one and phase two are sampled pins; bus cycles follow them.
// R2 - A rising edge on the restart pin starts the restart sequence.
// R3 - Upper address byte is all ones while restart runs.
// R4 - Program counter loads high byte from FFFE, then low from FFFF.
// R5 - Restart sets the interrupt mask until the core clears it.
// R6 - The system holds restart low at least eight clock periods.
// R7 - After restart release, FFFE appears at the next phase one.
// R8 - Valid-address strobe is high only while the address is valid.
// R9 - Sixteen address lines with output enables, releasable.
// R10 - Float input releases address and direction, forces strobe low.
// R11 - The DMA master raises float at phase one and stops clocks.
// R12 - The DMA master keeps the floated state under 50 us.
// R13 - Eight-line two-way data bus with output enable.
// R14 - Data drivers enable only while data_driver_enable is high.
// R15 - Data drivers stay off during read cycles.
// R16 - The system holds data_driver_enable low when another owns data.
// R17 - Direction is high for read and idle, low for write.
// R18 - Direction line floats while halted or floated.
// R19 - Halt stops at instruction end; bus free, strobe low, lines off.
// R20 - Bus-available goes high when stopped by halt or wait.
// R21 - The controller pulses halt high one phase one to step.
// R22 - Halt is sampled at phase-one rising edges; float engages at one, releases on the level.
module cbi_bus_ctrl (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Two-phase clock and control pins.
    input wire logic phi1_in,
    input wire logic phi2_in,
    input wire logic restart_n_in,
    input wire logic halt_n_in,
    input wire logic bus_float_control_in,
    input wire logic data_driver_enable_in,
    // Address, direction and status pins.
    output logic [15:0] addr_out,
    output logic addr_oe_out,
    output logic rw_out,
    output logic rw_oe_out,
    output logic valid_address_strobe_out,
    output logic bus_available_out,
    // Data bus pins.
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    // Core side.
    input wire logic core_req_valid_in,
    input wire cbi_pkg::cbi_bus_req_s core_req_in,
    input wire logic core_instr_end_in,
    input wire logic core_wait_in,
    input wire logic core_mask_clear_in,
    output logic core_ack_out,
    output logic [7:0] core_rdata_out,
    output logic [15:0] core_pc_out,
    output logic core_pc_valid_out,
    output logic core_irq_mask_out
);
    import cbi_pkg::*;

    typedef struct packed {
        cbi_state_e state;
        logic armed;
        logic float_q;
        logic active;
        logic write;
        logic [15:0] addr;
        logic addr_oe;
        logic rw;
        logic rw_oe;
        logic strobe;
        logic ba;
        logic [7:0] wdata;
        logic data_oe;
        logic ack;
        logic [7:0] rdata;
        logic [15:0] pc;
        logic pc_valid;
        logic mask;
    } cbi_ctrl_s;

    cbi_ctrl_s st_reg;
    cbi_ctrl_s st_next;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;
    logic [PIN_W-1:0] pin_fall;
    logic phi1_rise;
    logic phi2_fall;
    logic [7:0] data_sync;

    function automatic logic in_restart(input cbi_state_e s);
        in_restart = (s == ST_RESET) || (s == ST_VEC_HI) ||
            (s == ST_VEC_LO);
    endfunction

    function automatic logic is_stopped(input cbi_state_e s);
        is_stopped = (s == ST_HALT) || (s == ST_WAIT);
    endfunction

    // ==========================================================
    // Pin synchronisation.
    assign pin_raw = {data_in, data_driver_enable_in,
        bus_float_control_in, halt_n_in, restart_n_in, phi2_in, phi1_in};

    // Clock phases are oversampled, never used as clocks.  see R1
    cbi_pin_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pins_in(pin_raw),
        .level_out(pin_lvl),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    assign phi1_rise = pin_rise[PIN_PHI1];
    assign phi2_fall = pin_fall[PIN_PHI2];
    assign data_sync = pin_lvl[PIN_DATA_LSB +: DATA_W];

    // ==========================================================
    // Sequencer and pin drivers.
    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        // Data is read late in phase two, when it is settled.
        if (phi2_fall) begin
            case (st_reg.state)
                ST_VEC_HI: st_next.pc[15:8] = data_sync; // see R4
                ST_VEC_LO: st_next.pc[7:0] = data_sync; // see R4
                ST_RUN: begin
                    if (st_reg.active && !st_reg.write) begin
                        st_next.rdata = data_sync;
                        st_next.ack = 1'b1;
                    end else if (st_reg.active) begin
                        st_next.ack = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Float engages at a phase-one edge, releases on the level.
        if (phi1_rise && pin_lvl[PIN_FLOAT]) begin
            st_next.float_q = 1'b1; // see R22
        end else if (!pin_lvl[PIN_FLOAT]) begin
            st_next.float_q = 1'b0;
        end
        if (phi1_rise) begin
            st_next.active = 1'b0;
            st_next.write = 1'b0;
        end
        case (st_reg.state)
            ST_RESET: begin
                st_next.pc_valid = 1'b0;
                st_next.mask = 1'b1; // see R5
                if (pin_rise[PIN_RESET_N]) begin
                    st_next.armed = 1'b1; // see R2
                end
                if (st_reg.armed && phi1_rise) begin
                    st_next.state = ST_VEC_HI; // see R7
                    st_next.addr = VEC_HI_ADDR;
                    st_next.armed = 1'b0;
                end else begin
                    st_next.addr = {UPPER_ONES, DATA_RESET}; // see R3
                end
            end
            ST_VEC_HI: begin
                if (phi1_rise) begin
                    st_next.state = ST_VEC_LO; // see R4
                    st_next.addr = VEC_LO_ADDR;
                end
            end
            ST_VEC_LO: begin
                if (phi1_rise) begin
                    st_next.state = ST_RUN;
                    st_next.pc_valid = 1'b1;
                end
            end
            ST_RUN: begin
                if (phi1_rise && !st_next.float_q) begin
                    if (!pin_lvl[PIN_HALT_N] && core_instr_end_in) begin
                        st_next.state = ST_HALT; // see R19
                    end else if (core_wait_in && core_instr_end_in) begin
                        st_next.state = ST_WAIT; // see R20
                    end else if (core_req_valid_in) begin
                        st_next.active = 1'b1;
                        st_next.write = core_req_in.write;
                        st_next.addr = core_req_in.addr;
                        st_next.wdata = core_req_in.wdata;
                    end
                end
            end
            ST_HALT: begin
                // A one-phase high pulse on halt lets one step run.
                if (phi1_rise && pin_lvl[PIN_HALT_N]) begin
                    st_next.state = ST_RUN; // see R21
                end
            end
            ST_WAIT: begin
                if (phi1_rise && !core_wait_in) begin
                    st_next.state = ST_RUN;
                end
            end
            default: begin
                st_next.state = ST_RESET;
            end
        endcase
        // The restart pin held low overrides the state, bus cycle, arming and address.
        if (!pin_lvl[PIN_RESET_N]) begin
            st_next.state = ST_RESET;
            st_next.active = 1'b0;
            st_next.write = 1'b0;
            st_next.armed = 1'b0;
            st_next.addr = {UPPER_ONES, DATA_RESET}; // see R3
        end
        // Core clears the mask; the restart setting wins.
        if (core_mask_clear_in && !in_restart(st_next.state)) begin
            st_next.mask = 1'b0;
        end
        st_next.addr_oe = !st_next.float_q &&
            !is_stopped(st_next.state); // see R9, R10
        st_next.rw_oe = !st_next.float_q &&
            !is_stopped(st_next.state); // see R18
        st_next.rw = !(st_next.active && st_next.write); // see R17
        st_next.strobe = !st_next.float_q && (st_next.active ||
            st_next.state == ST_VEC_HI ||
            st_next.state == ST_VEC_LO); // see R8
        st_next.ba = !st_next.float_q &&
            is_stopped(st_next.state); // see R20
        st_next.data_oe = st_next.active && st_next.write &&
            pin_lvl[PIN_DDE]; // see R14, R15
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_reg <= '0;
            st_reg.state <= ST_RESET;
            st_reg.rw <= 1'b1;
            st_reg.mask <= 1'b1;
            st_reg.addr <= {UPPER_ONES, DATA_RESET};
            st_reg.pc <= PC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register.
    assign addr_out = st_reg.addr;
    assign addr_oe_out = st_reg.addr_oe;
    assign rw_out = st_reg.rw;
    assign rw_oe_out = st_reg.rw_oe;
    assign valid_address_strobe_out = st_reg.strobe;
    assign bus_available_out = st_reg.ba;
    assign data_out = st_reg.wdata; // see R13
    assign data_oe_out = st_reg.data_oe;
    assign core_ack_out = st_reg.ack;
    assign core_rdata_out = st_reg.rdata;
    assign core_pc_out = st_reg.pc;
    assign core_pc_valid_out = st_reg.pc_valid;
    assign core_irq_mask_out = st_reg.mask;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    a_float_release: // see R10
    assert property (st_reg.float_q |-> !addr_oe_out && !rw_oe_out &&
        !valid_address_strobe_out && !bus_available_out)
    else $error("float did not release the bus");

    a_restart_upper: // see R3
    assert property (in_restart(st_reg.state) |-> addr_out[15:8] ==
        UPPER_ONES)
    else $error("upper address not all ones in restart");

    a_vec_order: // see R4
    assert property ($rose(st_reg.state == ST_VEC_LO) |->
        $past(st_reg.state) == ST_VEC_HI && addr_out == VEC_LO_ADDR)
    else $error("low vector not after high vector");

    a_vec_first: // see R7
    assert property (st_reg.state == ST_RESET && st_reg.armed &&
        phi1_rise && pin_lvl[PIN_RESET_N] |=> addr_out == VEC_HI_ADDR &&
        st_reg.state == ST_VEC_HI)
    else $error("first vector not presented at phase one");

    a_mask_restart: // see R5
    assert property ($rose(core_pc_valid_out) |-> core_irq_mask_out)
    else $error("mask clear after restart");

    a_read_no_drive: // see R15
    assert property (data_oe_out |-> !rw_out && st_reg.write)
    else $error("data driven during read");

    a_dde_gate: // see R14
    assert property (data_oe_out |-> $past(pin_lvl[PIN_DDE]))
    else $error("data driven without enable");

    a_idle_read: // see R17
    assert property (!st_reg.active |-> rw_out)
    else $error("direction low while idle");

    a_halt_stop: // see R19
    assert property (st_reg.state == ST_HALT |-> !valid_address_strobe_out
        && !addr_oe_out && !rw_oe_out &&
        (bus_available_out || st_reg.float_q))
    else $error("halt does not free the bus");

    a_halt_entry: // see R22
    assert property ($rose(st_reg.state == ST_HALT) |->
        $past(phi1_rise) && !$past(pin_lvl[PIN_HALT_N]))
    else $error("halt entered off a phase-one edge");

endmodule

// [bench/cbi_far_model.sv]
// Far side of the bus: two-phase clock source, DMA controller, memory.
// Assumes clk_in at 250 MHz and that the bench asks for DMA by level.
module cbi_far_model (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // DMA request from the bench.
    input wire logic dma_req_in,
    // Processor bus pins.
    input wire logic [15:0] addr_in,
    input wire logic addr_oe_in,
    input wire logic rw_in,
    input wire logic strobe_in,
    input wire logic [7:0] cpu_data_in,
    input wire logic cpu_oe_in,
    // Clocks, float control and resolved data bus.
    output logic phi1_out,
    output logic phi2_out,
    output logic float_out,
    output logic [7:0] bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_reg;
    logic [7:0] last_reg;
    logic mem_on;
    // ========================================================
    // Clock phases and DMA float.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_reg <= 5'h00;
            float_out <= 1'b0;
            last_reg <= 8'h00;
        end else begin
            last_reg <= bus_out;
            if (dma_req_in && !float_out && cnt_reg == 5'h1F) begin
                float_out <= 1'b1;
                cnt_reg <= 5'h00;
            end else if (float_out) begin
                float_out <= dma_req_in;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end
    // The phases never overlap; a floated bus parks phase one high.
    assign phi1_out = cnt_reg <= 5'h0D;
    assign phi2_out = cnt_reg >= 5'h10 && cnt_reg <= 5'h1D;
    // ========================================================
    // Memory answers reads; an undriven bus keeps toggling.
    assign mem_on = strobe_in === 1'b1 && addr_oe_in && rw_in === 1'b1;
    always_comb begin
        if (cpu_oe_in && mem_on) begin
            bus_out = 8'hXX;
        end else if (cpu_oe_in) begin
            bus_out = cpu_data_in;
        end else if (mem_on) begin
            bus_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A;
        end else begin
            bus_out = ~last_reg;
        end
    end
endmodule

// [bench/tb_cpu_bus_interface_control.sv]
// Self-checking bench for the bus interface and processor control.
// Assumes cbi_far_model supplies clocks, DMA float and memory.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_cpu_bus_interface_control;
    timeunit 1ns;
    timeprecision 1ps;
    import cbi_pkg::*;
    logic clk_in, reset_in, phi1_in, phi2_in, restart_n_in, halt_n_in;
    logic bus_float_control_in, data_driver_enable_in, dma_req;
    logic [15:0] addr_out, core_pc_out;
    logic addr_oe_out, rw_out, rw_oe_out, valid_address_strobe_out;
    logic bus_available_out, data_oe_out, core_req_valid_in;
    logic [7:0] data_bus, data_out, core_rdata_out;
    cbi_bus_req_s core_req_in, nr;
    logic core_instr_end_in, core_wait_in, core_mask_clear_in, nd;
    logic core_ack_out, core_pc_valid_out, core_irq_mask_out;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00004E95;
    logic [31:0] rv;
    cbi_bus_req_s q_req[$];
    logic q_dde[$];

    cbi_bus_ctrl DUT (.clk_in, .reset_in, .phi1_in, .phi2_in,
        .restart_n_in, .halt_n_in, .bus_float_control_in,
        .data_driver_enable_in, .addr_out, .addr_oe_out, .rw_out,
        .rw_oe_out, .valid_address_strobe_out, .bus_available_out,
        .data_in(data_bus), .data_out, .data_oe_out, .core_req_valid_in,
        .core_req_in, .core_instr_end_in, .core_wait_in,
        .core_mask_clear_in, .core_ack_out, .core_rdata_out, .core_pc_out,
        .core_pc_valid_out, .core_irq_mask_out);
    cbi_far_model far (.clk_in, .reset_in, .dma_req_in(dma_req),
        .addr_in(addr_out), .addr_oe_in(addr_oe_out), .rw_in(rw_out),
        .strobe_in(valid_address_strobe_out), .cpu_data_in(data_out),
        .cpu_oe_in(data_oe_out), .phi1_out(phi1_in), .phi2_out(phi2_in),
        .float_out(bus_float_control_in), .bus_out(data_bus));

    // ========================================================
    // Helpers.
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] mval(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    function logic pick(input int sel);
        case (sel)
            0: return bus_available_out;
            1: return core_ack_out;
            default: return addr_oe_out;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wait_for(input int sel, input logic lvl);
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_in);
            if (pick(sel) === lvl) break;
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bus_op(input cbi_bus_req_s r, input logic d);
        @(posedge clk_in);
        q_req.push_back(r);
        q_dde.push_back(d);
        core_req_in <= r;
        data_driver_enable_in <= d;
        core_req_valid_in <= 1'b1;
        wait_for(1, 1'b1);
        @(posedge clk_in);
        core_req_valid_in <= 1'b0;
    endtask
    task automatic do_restart();
        logic [1:0] idx;
        idx = 2'h0;
        @(posedge clk_in);
        restart_n_in <= 1'b0;
        tick(8 * 32);
        @(negedge clk_in);
        `CHK("upper", UPPER_ONES, addr_out[15:8])
        @(posedge clk_in);
        restart_n_in <= 1'b1;
        for (int i = 0; i < 400 && core_pc_valid_out !== 1'b1; i++) begin
            @(negedge clk_in);
            if (valid_address_strobe_out === 1'b1) begin
                if (idx == 2'h0 && addr_out === VEC_HI_ADDR) idx = 2'h1;
                if (idx == 2'h1 && addr_out === VEC_LO_ADDR) idx = 2'h2;
            end
        end
        `CHK("vectors", 2'h2, idx)
        `CHK("pc", {mval(VEC_HI_ADDR), mval(VEC_LO_ADDR)}, core_pc_out)
        `CHK("mask", 1'b1, core_irq_mask_out)
    endtask

    // ========================================================
    // Clock, timeout and result watcher.
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    always @(negedge clk_in) begin
        if (core_ack_out === 1'b1) begin
            if (q_req.size() == 0) `CHK("note", 1'b1, 1'b0)
            else begin
                nr = q_req.pop_front();
                nd = q_dde.pop_front();
                `CHK("addr", nr.addr, addr_out)
                `CHK("rw", ~nr.write, rw_out)
                `CHK("strobe", 1'b1, valid_address_strobe_out)
                `CHK("data_oe", nr.write & nd, data_oe_out)
                if (nr.write) `CHK("wdata", nr.wdata, data_out)
                else `CHK("rdata", mval(nr.addr), core_rdata_out)
            end
        end
    end

    // ========================================================
    // Main sequence.
    initial begin
        clk_in = 1'b0;
        reset_in = 1'b1;
        restart_n_in = 1'b0;
        halt_n_in = 1'b1;
        data_driver_enable_in = 1'b0;
        core_req_valid_in = 1'b0;
        core_req_in = '0;
        core_instr_end_in = 1'b0;
        core_wait_in = 1'b0;
        core_mask_clear_in = 1'b0;
        dma_req = 1'b0;
        tick(6);
        reset_in <= 1'b0;
        do_restart();
        bus_op(cbi_bus_req_s'(25'h11234A5), 1'b1);
        bus_op(cbi_bus_req_s'(25'h0800100), 1'b1);
        repeat (16) begin
            rv = rnd();
            bus_op(cbi_bus_req_s'(rv[24:0]), rv[25]);
        end
        tick(80);
        @(negedge clk_in);
        `CHK("idle rw", 1'b1, rw_out)
        `CHK("idle strobe", 1'b0, valid_address_strobe_out)
        @(posedge clk_in);
        halt_n_in <= 1'b0;
        tick(96);
        @(negedge clk_in);
        `CHK("halt early", 1'b0, bus_available_out)
        @(posedge clk_in);
        core_instr_end_in <= 1'b1;
        wait_for(0, 1'b1);
        `CHK("halt ba", 1'b1, bus_available_out)
        `CHK("halt strobe", 1'b0, valid_address_strobe_out)
        `CHK("halt addr_oe", 1'b0, addr_oe_out)
        `CHK("halt rw_oe", 1'b0, rw_oe_out)
        @(posedge clk_in);
        halt_n_in <= 1'b1;
        wait_for(0, 1'b0);
        `CHK("run ba", 1'b0, bus_available_out)
        @(posedge clk_in);
        halt_n_in <= 1'b0;
        wait_for(0, 1'b1);
        `CHK("step ba", 1'b1, bus_available_out)
        @(posedge clk_in);
        halt_n_in <= 1'b1;
        wait_for(0, 1'b0);
        `CHK("step run", 1'b0, bus_available_out)
        @(posedge clk_in);
        core_wait_in <= 1'b1;
        wait_for(0, 1'b1);
        `CHK("wait ba", 1'b1, bus_available_out)
        @(posedge clk_in);
        core_wait_in <= 1'b0;
        core_instr_end_in <= 1'b0;
        wait_for(0, 1'b0);
        `CHK("woke ba", 1'b0, bus_available_out)
        @(posedge clk_in);
        data_driver_enable_in <= 1'b0;
        dma_req <= 1'b1;
        wait_for(3, 1'b0);
        tick(4);
        @(negedge clk_in);
        `CHK("float addr_oe", 1'b0, addr_oe_out)
        `CHK("float rw_oe", 1'b0, rw_oe_out)
        `CHK("float strobe", 1'b0, valid_address_strobe_out)
        `CHK("float ba", 1'b0, bus_available_out)
        `CHK("float data_oe", 1'b0, data_oe_out)
        @(posedge clk_in);
        dma_req <= 1'b0;
        wait_for(3, 1'b1);
        `CHK("unfloat", 1'b1, addr_oe_out)
        bus_op(cbi_bus_req_s'(25'h0ABCD00), 1'b0);
        core_mask_clear_in <= 1'b1;
        tick(2);
        core_mask_clear_in <= 1'b0;
        tick(4);
        @(negedge clk_in);
        `CHK("mask clear", 1'b0, core_irq_mask_out)
        do_restart();
        tick(40);
        `CHK("notes left", 0, q_req.size())
        end_sim();
    end
endmodule
